/* File: include/sxt_pkg.sv */
// Shared constants, types and helpers for the nibble/skip/table/xor executor
package sxt_pkg;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int PAGE_AW = 8;
    localparam int DMEM_AW = 8;
    localparam int BUS_AW = 13;
    localparam int FLAGS_W = 4;
    localparam int PROG_AW_DEFAULT = 10;
    localparam int CYC_W_DEFAULT = 16;

    // Register byte offsets
    localparam logic [12:0] OFS_CMD = 13'h0000;
    localparam logic [12:0] OFS_STATUS = 13'h0004;
    localparam logic [12:0] OFS_WORK = 13'h0008;
    localparam logic [12:0] OFS_TPL = 13'h000c;
    localparam logic [12:0] OFS_TPH = 13'h0010;
    localparam logic [12:0] OFS_TLATCH = 13'h0014;
    localparam logic [12:0] OFS_PAGE = 13'h0018;
    localparam logic [12:0] OFS_CYCLES = 13'h001c;
    // Memory windows: address[12:10] == 1 is data memory, address[12] == 1 is program memory
    localparam logic [2:0] DMEM_SEL = 3'h1;
    localparam logic PMEM_SEL = 1'b1;

    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_BIT_LSB = 16;
    localparam int CMD_IMM_LSB = 24;

    // Status bits
    localparam int ST_Z = 0;
    localparam int ST_BUSY = 8;
    localparam int ST_SQUASH = 9;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;

    typedef enum logic [3:0] {
        OP_NIBBLE_SWAP,
        OP_NIBBLE_EXCHANGE_TO_WORKING,
        OP_SKIP_ON_NULL_BYTE,
        OP_COPY_AND_SKIP_ON_NULL,
        OP_SKIP_ON_NULL_BIT,
        OP_PAGED_PROGRAM_WORD_FETCH,
        OP_CURRENT_PAGE_WORD_FETCH,
        OP_LAST_PAGE_WORD_FETCH,
        OP_XOR_TO_WORKING,
        OP_XOR_INTO_MEMORY,
        OP_XOR_IMMEDIATE
    } sxt_op_t;

    typedef enum logic [1:0] {SXT_IDLE, SXT_EXEC, SXT_DUMMY} sxt_state_t;
    typedef enum logic [1:0] {TBL_PAGED, TBL_CURRENT, TBL_LAST} sxt_tbl_mode_t;

    function automatic logic [7:0] swap_nibbles(input logic [7:0] b);
        return {b[3:0], b[7:4]};
    endfunction

    function automatic logic is_null(input logic [7:0] b);
        return b == 8'h00;
    endfunction
endpackage

/* File: rtl/sxt_alu.sv */
// Combinational result, flag and skip computation for one instruction
`timescale 1ns/1ps
`default_nettype none
module sxt_alu (
    input wire sxt_pkg::sxt_op_t op,
    input wire logic [7:0] work,
    input wire logic [7:0] mem_byte,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] imm,
    input wire logic [15:0] prog_word,
    output logic [7:0] res_work,
    output logic [7:0] res_mem,
    output logic wr_work,
    output logic wr_mem,
    output logic wr_latch,
    output logic upd_z,
    output logic res_z,
    output logic skip
);
    import sxt_pkg::*;
    logic [7:0] xr;

    always_comb begin
        xr = work ^ ((op == OP_XOR_IMMEDIATE) ? imm : mem_byte);
        res_work = work;
        res_mem = mem_byte;
        wr_work = 1'b0;
        wr_mem = 1'b0;
        wr_latch = 1'b0;
        upd_z = 1'b0;
        skip = 1'b0;
        res_z = is_null(xr);
        unique case (op)
            OP_NIBBLE_SWAP: begin
                res_mem = swap_nibbles(mem_byte);
                wr_mem = 1'b1;
            end
            OP_NIBBLE_EXCHANGE_TO_WORKING: begin
                res_work = swap_nibbles(mem_byte);
                wr_work = 1'b1;
            end
            OP_SKIP_ON_NULL_BYTE: skip = is_null(mem_byte);
            OP_COPY_AND_SKIP_ON_NULL: begin
                res_work = mem_byte;
                wr_work = 1'b1;
                skip = is_null(mem_byte);
            end
            OP_SKIP_ON_NULL_BIT: skip = ~mem_byte[bit_sel];
            OP_PAGED_PROGRAM_WORD_FETCH, OP_CURRENT_PAGE_WORD_FETCH, OP_LAST_PAGE_WORD_FETCH: begin
                res_mem = prog_word[7:0];
                wr_mem = 1'b1;
                wr_latch = 1'b1;
            end
            OP_XOR_TO_WORKING, OP_XOR_IMMEDIATE: begin
                res_work = xr;
                wr_work = 1'b1;
                upd_z = 1'b1;
            end
            OP_XOR_INTO_MEMORY: begin
                res_mem = xr;
                wr_mem = 1'b1;
                upd_z = 1'b1;
            end
            default: begin
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: rtl/sxt_exec.sv */
// Executor for nibble exchange, zero skips, table fetches and xor, with Avalon-MM slave
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Swap nibbles in place, flags untouched
// - Swapped byte to working register, memory kept
// - Skip next when data byte is zero
// - Skip replaces next instruction with dummy cycle
// - Copy byte to working, skip if zero
// - Skip next when selected bit is zero
// - Fetch word at high:low pointers, split
// - Fetch word in current page, split
// - Fetch word in last page, split
// - Xor memory into working, zero flag only
// - Xor working into memory, zero flag only
// - Xor immediate into working, zero flag only
module sxt_exec #(
    parameter int PROG_AW = sxt_pkg::PROG_AW_DEFAULT,
    parameter int CYC_W = sxt_pkg::CYC_W_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [sxt_pkg::BUS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic zero_flag,
    output logic dummy_slot
);
    import sxt_pkg::*;
    localparam int PG_W = PROG_AW - PAGE_AW;

    sxt_state_t state, next_state;
    sxt_op_t cmd_op, next_cmd_op;
    logic [7:0] cmd_addr, next_cmd_addr;
    logic [2:0] cmd_bit, next_cmd_bit;
    logic [7:0] cmd_imm, next_cmd_imm;
    logic [7:0] work, next_work;
    logic [7:0] tpl, next_tpl;
    logic [7:0] tlatch, next_tlatch;
    logic [PG_W-1:0] tph, next_tph;
    logic [PG_W-1:0] page, next_page;
    logic [FLAGS_W-1:0] flags, next_flags;
    logic squash, next_squash;
    logic [CYC_W-1:0] cycles, next_cycles;
    logic rd_ack, next_rd_ack;
    logic [31:0] rdata, next_rdata;

    logic [7:0] dmem [2**DMEM_AW];
    logic [WORD_W-1:0] pmem [2**PROG_AW];
    logic dm_we;
    logic [DMEM_AW-1:0] dm_waddr;
    logic [7:0] dm_wdata;
    logic pm_we_lo, pm_we_hi;
    logic [PROG_AW-1:0] pm_idx;

    logic bus_idle, wr_take, exec, sel_dmem, sel_pmem;
    logic [7:0] mem_byte;
    logic [PROG_AW-1:0] tbl_addr;
    logic [WORD_W-1:0] prog_word;
    sxt_tbl_mode_t tbl_mode;
    logic [7:0] res_work, res_mem;
    logic wr_work, wr_mem, wr_latch, upd_z, res_z, skip;
    logic [31:0] read_mux;

    assign bus_idle = (state == SXT_IDLE);
    assign exec = (state == SXT_EXEC);
    // Writes stall while an instruction is in flight, so memory ports never collide
    assign avs_waitrequest = avs_read ? ~rd_ack : (avs_write & ~bus_idle);
    assign wr_take = avs_write & ~avs_read & bus_idle;
    assign sel_dmem = (avs_address[12:10] == DMEM_SEL);
    assign pm_idx = avs_address[PROG_AW+1:2];
    assign sel_pmem = (avs_address[12] == PMEM_SEL) && (int'(avs_address[11:2]) < (2 ** PROG_AW));
    assign mem_byte = dmem[cmd_addr];
    assign prog_word = pmem[tbl_addr];
    assign avs_readdata = rdata;
    assign zero_flag = flags[ST_Z];
    assign dummy_slot = (state == SXT_DUMMY);

    always_comb begin
        unique case (cmd_op)
            OP_CURRENT_PAGE_WORD_FETCH: tbl_mode = TBL_CURRENT;
            OP_LAST_PAGE_WORD_FETCH: tbl_mode = TBL_LAST;
            default: tbl_mode = TBL_PAGED;
        endcase
    end

    sxt_tbl_addr #(.PROG_AW(PROG_AW)) u_tbl (
        .mode(tbl_mode),
        .tpl(tpl),
        .tph(tph),
        .cur_page(page),
        .addr(tbl_addr)
    );

    sxt_alu u_alu (
        .op(cmd_op),
        .work(work),
        .mem_byte(mem_byte),
        .bit_sel(cmd_bit),
        .imm(cmd_imm),
        .prog_word(prog_word),
        .res_work(res_work),
        .res_mem(res_mem),
        .wr_work(wr_work),
        .wr_mem(wr_mem),
        .wr_latch(wr_latch),
        .upd_z(upd_z),
        .res_z(res_z),
        .skip(skip)
    );

    always_comb begin
        read_mux = 32'h0000_0000;
        if (sel_pmem) begin
            read_mux = {16'h0000, pmem[pm_idx]};
        end else if (sel_dmem) begin
            read_mux = {24'h00_0000, dmem[avs_address[DMEM_AW+1:2]]};
        end else begin
            unique case (avs_address)
                OFS_CMD: read_mux = {cmd_imm, 5'h00, cmd_bit, cmd_addr, 4'h0, cmd_op};
                OFS_STATUS: read_mux = {22'h00_0000, squash, ~bus_idle, 4'h0, flags};
                OFS_WORK: read_mux = {24'h00_0000, work};
                OFS_TPL: read_mux = {24'h00_0000, tpl};
                OFS_TPH: read_mux = {{(32-PG_W){1'b0}}, tph};
                OFS_TLATCH: read_mux = {24'h00_0000, tlatch};
                OFS_PAGE: read_mux = {{(32-PG_W){1'b0}}, page};
                OFS_CYCLES: read_mux = {{(32-CYC_W){1'b0}}, cycles};
                default: read_mux = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        next_state = state;
        next_cmd_op = cmd_op;
        next_cmd_addr = cmd_addr;
        next_cmd_bit = cmd_bit;
        next_cmd_imm = cmd_imm;
        next_work = work;
        next_tpl = tpl;
        next_tph = tph;
        next_tlatch = tlatch;
        next_page = page;
        next_flags = flags;
        next_squash = squash;
        next_cycles = cycles;
        next_rd_ack = avs_read & ~rd_ack;
        next_rdata = (avs_read & ~rd_ack) ? read_mux : rdata;
        dm_we = 1'b0;
        dm_waddr = avs_address[DMEM_AW+1:2];
        dm_wdata = avs_writedata[7:0];
        pm_we_lo = 1'b0;
        pm_we_hi = 1'b0;
        unique case (state)
            SXT_IDLE: begin
                if (wr_take && sel_pmem) begin
                    pm_we_lo = avs_byteenable[0];
                    pm_we_hi = avs_byteenable[1];
                end else if (wr_take && sel_dmem) begin
                    dm_we = avs_byteenable[0];
                end else if (wr_take && avs_address == OFS_CMD && avs_byteenable != 4'h0) begin
                    next_cmd_op = sxt_op_t'(avs_writedata[CMD_OP_LSB+:4]);
                    next_cmd_addr = avs_writedata[CMD_ADDR_LSB+:8];
                    next_cmd_bit = avs_writedata[CMD_BIT_LSB+:3];
                    next_cmd_imm = avs_writedata[CMD_IMM_LSB+:8];
                    // A pending skip turns this fetched instruction into a dummy
                    next_state = squash ? SXT_DUMMY : SXT_EXEC;
                end else if (wr_take && avs_byteenable[0]) begin
                    unique case (avs_address)
                        OFS_STATUS: next_flags = avs_writedata[FLAGS_W-1:0];
                        OFS_WORK: next_work = avs_writedata[7:0];
                        OFS_TPL: next_tpl = avs_writedata[7:0];
                        OFS_TPH: next_tph = avs_writedata[PG_W-1:0];
                        OFS_PAGE: next_page = avs_writedata[PG_W-1:0];
                        default: begin
                        end
                    endcase
                end
            end
            SXT_EXEC: begin
                if (wr_work) begin
                    next_work = res_work;
                end
                if (wr_latch) begin
                    next_tlatch = prog_word[15:8];
                end
                if (upd_z) begin
                    next_flags[ST_Z] = res_z;
                end
                dm_we = wr_mem;
                dm_waddr = cmd_addr;
                dm_wdata = res_mem;
                next_squash = skip;
                next_cycles = cycles + 1'b1;
                next_state = SXT_IDLE;
            end
            SXT_DUMMY: begin
                // Dummy cycle has no effect other than consuming the slot
                next_squash = 1'b0;
                next_cycles = cycles + 1'b1;
                next_state = SXT_IDLE;
            end
            default: next_state = SXT_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= SXT_IDLE;
            cmd_op <= OP_NIBBLE_SWAP;
            cmd_addr <= RST_BYTE;
            cmd_bit <= 3'h0;
            cmd_imm <= RST_BYTE;
            work <= RST_BYTE;
            tpl <= RST_BYTE;
            tph <= '0;
            tlatch <= RST_BYTE;
            page <= '0;
            flags <= RST_FLAGS;
            squash <= 1'b0;
            cycles <= '0;
            rd_ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            cmd_op <= next_cmd_op;
            cmd_addr <= next_cmd_addr;
            cmd_bit <= next_cmd_bit;
            cmd_imm <= next_cmd_imm;
            work <= next_work;
            tpl <= next_tpl;
            tph <= next_tph;
            tlatch <= next_tlatch;
            page <= next_page;
            flags <= next_flags;
            squash <= next_squash;
            cycles <= next_cycles;
            rd_ack <= next_rd_ack;
            rdata <= next_rdata;
        end
    end

    // Memories are not reset; software loads them before use
    always_ff @(posedge mclk) begin
        if (dm_we) begin
            dmem[dm_waddr] <= dm_wdata;
        end
        if (pm_we_lo) begin
            pmem[pm_idx][7:0] <= avs_writedata[7:0];
        end
        if (pm_we_hi) begin
            pmem[pm_idx][15:8] <= avs_writedata[15:8];
        end
    end

    AST_SWAP_IN_PLACE: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_NIBBLE_SWAP |=> dmem[$past(cmd_addr)] == swap_nibbles($past(mem_byte))
            && flags == $past(flags) && work == $past(work))
        else $error("in-place nibble swap wrong");

    AST_EXCHANGE_TO_WORK: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_NIBBLE_EXCHANGE_TO_WORKING |=> work == swap_nibbles($past(mem_byte))
            && dmem[$past(cmd_addr)] == $past(mem_byte))
        else $error("nibble exchange to working register wrong");

    AST_SKIP_BYTE: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_SKIP_ON_NULL_BYTE |=> squash == ($past(mem_byte) == 8'h00)
            && $stable(flags) && $stable(work))
        else $error("byte zero skip decision wrong");

    AST_DUMMY_SLOT: assert property (@(posedge mclk) disable iff (!rst_n)
        squash && wr_take && avs_address == OFS_CMD && avs_byteenable != 4'h0
            |=> dummy_slot ##1 (bus_idle && !squash && $stable(work) && $stable(flags) && $stable(tlatch)))
        else $error("skipped instruction not replaced by dummy");

    AST_COPY_SKIP: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_COPY_AND_SKIP_ON_NULL |=> work == $past(mem_byte)
            && squash == ($past(mem_byte) == 8'h00) && $stable(flags))
        else $error("copy and skip wrong");

    AST_SKIP_BIT: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_SKIP_ON_NULL_BIT |=> squash == !$past(mem_byte[cmd_bit]))
        else $error("bit zero skip decision wrong");

    AST_PAGED_FETCH: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_PAGED_PROGRAM_WORD_FETCH |-> tbl_addr == {tph, tpl}
            ##1 tlatch == $past(prog_word[15:8]) && dmem[$past(cmd_addr)] == $past(prog_word[7:0]))
        else $error("paged table fetch wrong");

    AST_CURRENT_FETCH: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_CURRENT_PAGE_WORD_FETCH |-> tbl_addr == {page, tpl}
            ##1 tlatch == $past(prog_word[15:8]) && dmem[$past(cmd_addr)] == $past(prog_word[7:0]))
        else $error("current page table fetch wrong");

    AST_LAST_FETCH: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_LAST_PAGE_WORD_FETCH |-> tbl_addr[PROG_AW-1:PAGE_AW] == {PG_W{1'b1}}
            ##1 tlatch == $past(prog_word[15:8]) && dmem[$past(cmd_addr)] == $past(prog_word[7:0]) && $stable(flags))
        else $error("last page table fetch wrong");

    AST_XOR_WORK: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_XOR_TO_WORKING |=> work == ($past(work) ^ $past(mem_byte))
            && flags[FLAGS_W-1:1] == $past(flags[FLAGS_W-1:1]))
        else $error("xor to working register wrong");

    AST_XOR_MEM: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_XOR_INTO_MEMORY |=> dmem[$past(cmd_addr)] == ($past(work) ^ $past(mem_byte))
            && flags[ST_Z] == (($past(work) ^ $past(mem_byte)) == 8'h00) && $stable(work))
        else $error("xor into memory wrong");

    AST_XOR_IMM: assert property (@(posedge mclk) disable iff (!rst_n)
        exec && cmd_op == OP_XOR_IMMEDIATE |=> work == ($past(work) ^ $past(cmd_imm))
            && zero_flag == (work == 8'h00))
        else $error("xor immediate wrong");

    AST_READ_ONE_WAIT: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer not after exactly one wait cycle");

    COV_SWAP: cover property (@(posedge mclk) disable iff (!rst_n) exec && cmd_op == OP_NIBBLE_SWAP);
    COV_SKIP_DUMMY: cover property (@(posedge mclk) disable iff (!rst_n) exec && skip ##[1:20] dummy_slot);
    COV_TABLE: cover property (@(posedge mclk) disable iff (!rst_n) exec && wr_latch);
    COV_XOR_ZERO: cover property (@(posedge mclk) disable iff (!rst_n) exec && upd_z && res_z);
endmodule
`default_nettype wire

/* File: rtl/sxt_tbl_addr.sv */
// Program memory address forming for the three table fetch flavours
`timescale 1ns/1ps
`default_nettype none
module sxt_tbl_addr #(
    parameter int PROG_AW = 10
) (
    input wire sxt_pkg::sxt_tbl_mode_t mode,
    input wire logic [7:0] tpl,
    input wire logic [PROG_AW-sxt_pkg::PAGE_AW-1:0] tph,
    input wire logic [PROG_AW-sxt_pkg::PAGE_AW-1:0] cur_page,
    output logic [PROG_AW-1:0] addr
);
    import sxt_pkg::*;
    localparam int PG_W = PROG_AW - PAGE_AW;

    always_comb begin
        unique case (mode)
            TBL_PAGED: addr = {tph, tpl};
            TBL_CURRENT: addr = {cur_page, tpl};
            TBL_LAST: addr = {{PG_W{1'b1}}, tpl};
            default: addr = {tph, tpl};
        endcase
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the nibble, skip, table and xor executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sxt_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [BUS_AW-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic zero_flag;
    logic dummy_slot;
    logic [31:0] rdq;
    logic [7:0] waits;
    int miscompares = 0;
    int n_checks = 0;
    int dummies = 0;

    always #12.5 mclk = ~mclk;

    sxt_exec dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .zero_flag(zero_flag),
        .dummy_slot(dummy_slot));

    // Sampled mid-cycle so the count never races the state register
    always @(negedge mclk) begin
        if (dummy_slot === 1'b1) dummies <= dummies + 1;
    end

    task automatic conclude();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    // Keep leaves the request up so a following call can chain without an idle edge
    task automatic xfer(input logic wr, input logic [12:0] a, input logic [31:0] d, input bit keep);
        bit ok;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_byteenable <= 4'hf;
        waits = 8'h00;
        ok = 1'b0;
        // Waitrequest and read data are taken at the accepting edge; only the run timeout ends a wait
        while (!ok) begin
            @(posedge mclk);
            ok = (avs_waitrequest === 1'b0);
            if (!ok) waits++;
        end
        rdq = avs_readdata;
        if (!keep) begin
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask

    task automatic rd(input logic [12:0] a);
        xfer(1'b0, a, 32'h0, 1'b0);
    endtask

    task automatic cmd(input logic [3:0] op, input logic [7:0] m, input logic [2:0] b, input logic [7:0] imm,
        input bit keep = 1'b0);
        xfer(1'b1, OFS_CMD, {imm, 5'h00, b, m, 4'h0, op}, keep);
    endtask

    function automatic logic [12:0] dma(input logic [7:0] m);
        return 13'h0400 + {3'h0, m, 2'h0};
    endfunction

    task automatic t_reset();
        chk1("zero flag after reset", 1'b0, zero_flag);
        chk1("dummy slot after reset", 1'b0, dummy_slot);
        rd(OFS_WORK);
        chk8("work after reset", 8'h00, rdq[7:0]);
        rd(13'h0100);
        chk8("unmapped read", 8'h00, rdq[7:0]);
    endtask

    task automatic t_swap();
        wr(OFS_STATUS, 32'h0000000e);
        wr(dma(8'h10), 32'h000000a5);
        cmd(4'h0, 8'h10, 3'h0, 8'h00);
        rd(dma(8'h10));
        chk8("swapped byte", 8'h5a, rdq[7:0]);
        rd(OFS_STATUS);
        chk8("flags after swap", 8'h0e, {4'h0, rdq[3:0]});
        wr(OFS_WORK, 32'h0);
        wr(dma(8'h11), 32'h0000003c);
        cmd(4'h1, 8'h11, 3'h0, 8'h00);
        rd(OFS_WORK);
        chk8("swap into work", 8'hc3, rdq[7:0]);
        rd(dma(8'h11));
        chk8("source byte kept", 8'h3c, rdq[7:0]);
    endtask

    task automatic t_skip_byte();
        logic [7:0] c0;
        int d0;
        wr(dma(8'h20), 32'h0);
        wr(OFS_WORK, 32'h00000011);
        rd(OFS_CYCLES);
        c0 = rdq[7:0];
        d0 = dummies;
        cmd(4'h2, 8'h20, 3'h0, 8'h00, 1'b1);
        cmd(4'ha, 8'h00, 3'h0, 8'hff);
        chk8("stall after command", 8'h01, waits);
        rd(OFS_WORK);
        chk8("skipped xor left work", 8'h11, rdq[7:0]);
        chk8("dummy cycles", 8'h01, 8'(dummies - d0));
        rd(OFS_CYCLES);
        chk8("cycles for skip pair", 8'(c0 + 8'h02), rdq[7:0]);
        wr(dma(8'h20), 32'h00000001);
        cmd(4'h2, 8'h20, 3'h0, 8'h00);
        rd(OFS_STATUS);
        chk1("no skip on nonzero", 1'b0, rdq[ST_SQUASH]);
        cmd(4'ha, 8'h00, 3'h0, 8'hff);
        rd(OFS_WORK);
        chk8("next op ran", 8'hee, rdq[7:0]);
        rd(dma(8'h20));
        chk8("tested byte kept", 8'h01, rdq[7:0]);
    endtask

    task automatic t_copy_skip();
        wr(OFS_STATUS, 32'h0000000e);
        wr(dma(8'h21), 32'h0);
        wr(OFS_WORK, 32'h00000099);
        cmd(4'h3, 8'h21, 3'h0, 8'h00);
        rd(OFS_WORK);
        chk8("copied zero", 8'h00, rdq[7:0]);
        rd(OFS_STATUS);
        chk1("copy skip pending", 1'b1, rdq[ST_SQUASH]);
        chk8("flags after copy", 8'h0e, {4'h0, rdq[3:0]});
        cmd(4'hf, 8'h00, 3'h0, 8'h00);
        wr(dma(8'h21), 32'h00000077);
        cmd(4'h3, 8'h21, 3'h0, 8'h00);
        rd(OFS_WORK);
        chk8("copied value", 8'h77, rdq[7:0]);
        rd(OFS_STATUS);
        chk1("no skip on copy of nonzero", 1'b0, rdq[ST_SQUASH]);
    endtask

    task automatic t_skip_bit();
        logic [7:0] v;
        v = 8'h5a;
        wr(dma(8'h22), {24'h0, v});
        for (int i = 0; i < 8; i++) begin
            cmd(4'h4, 8'h22, 3'(i), 8'h00);
            rd(OFS_STATUS);
            chk1("bit skip pending", ~v[i], rdq[ST_SQUASH]);
            if (!v[i]) cmd(4'hf, 8'h00, 3'h0, 8'h00);
        end
    endtask

    task automatic t_table();
        logic [7:0] pg [3];
        pg = '{8'h02, 8'h01, 8'h03};
        for (int p = 0; p < 4; p++) begin
            wr(13'h1000 + {1'b0, 2'(p), 8'h34, 2'h0}, {16'h0, 8'hc0 | 8'(p), 8'h30 | 8'(p)});
        end
        wr(OFS_STATUS, 32'h0000000f);
        wr(OFS_TPL, 32'h00000034);
        wr(OFS_TPH, 32'h00000002);
        wr(OFS_PAGE, 32'h00000001);
        for (int k = 0; k < 3; k++) begin
            cmd(4'(5 + k), 8'(8'h30 + k), 3'h0, 8'h00);
            rd(dma(8'(8'h30 + k)));
            chk8("table low byte", 8'h30 | pg[k], rdq[7:0]);
            rd(OFS_TLATCH);
            chk8("table high latch", 8'hc0 | pg[k], rdq[7:0]);
        end
        rd(OFS_STATUS);
        chk8("flags after fetches", 8'h0f, {4'h0, rdq[3:0]});
    endtask

    task automatic t_xor();
        wr(OFS_STATUS, 32'h0000000e);
        wr(OFS_WORK, 32'h0000005a);
        wr(dma(8'h40), 32'h0000005a);
        cmd(4'h8, 8'h40, 3'h0, 8'h00);
        rd(OFS_WORK);
        chk8("xor to work", 8'h00, rdq[7:0]);
        rd(OFS_STATUS);
        chk8("flags zero result", 8'h0f, {4'h0, rdq[3:0]});
        wr(OFS_WORK, 32'h0000000f);
        wr(dma(8'h41), 32'h000000f0);
        cmd(4'h9, 8'h41, 3'h0, 8'h00);
        rd(dma(8'h41));
        chk8("xor into memory", 8'hff, rdq[7:0]);
        rd(OFS_WORK);
        chk8("work kept", 8'h0f, rdq[7:0]);
        rd(OFS_STATUS);
        chk8("flags nonzero result", 8'h0e, {4'h0, rdq[3:0]});
        wr(OFS_WORK, 32'h0000003c);
        cmd(4'ha, 8'h00, 3'h0, 8'h3c);
        rd(OFS_WORK);
        chk8("xor immediate", 8'h00, rdq[7:0]);
        chk1("zero flag pin set", 1'b1, zero_flag);
        cmd(4'ha, 8'h00, 3'h0, 8'h81);
        rd(OFS_WORK);
        chk8("xor immediate nonzero", 8'h81, rdq[7:0]);
        chk1("zero flag pin clear", 1'b0, zero_flag);
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_swap();
        t_skip_byte();
        t_copy_skip();
        t_skip_bit();
        t_table();
        t_xor();
        conclude();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        $display("unexpected run length: expected end before 5000 cycles, seen none");
        conclude();
    end
endmodule
`default_nettype wire
